/* logic/hrap_regs.svh */
// Register offsets, field positions, reset values and index constants for host register access
`ifndef HRAP_REGS_SVH
`define HRAP_REGS_SVH
`define HRAP_OFF_PINSEL1 12'h915
`define HRAP_OFF_PINSEL0 12'h914
`define HRAP_OFF_SCRATCH 12'h918
`define HRAP_OFF_STATUS 12'h919
`define HRAP_OFF_CTRL 12'h91a
`define HRAP_OFF_INPIN 12'h91b
`define HRAP_OFF_CB_LO 12'h000
`define HRAP_OFF_CB_HI 12'h7ff
`define HRAP_OFF_EXT_BASE 12'h900
`define HRAP_IDX_EXT_INDEX 8'h2e
`define HRAP_IDX_EXT_DATA 8'h2f
`define HRAP_IDX_SOCK_B 8'h40
`define HRAP_IDX_SCRATCH 8'h0e
`define HRAP_IDX_STATUS 8'h0f
`define HRAP_IDX_CTRL 8'h1f
`define HRAP_IDX_INPIN 8'h1e
`define HRAP_XIDX_PINSEL0 8'h14
`define HRAP_XIDX_PINSEL1 8'h15
`define HRAP_PINSEL_LSB 0
`define HRAP_PINSEL_MSB 1
`define HRAP_RST_BYTE 8'h00
`define HRAP_CTRL_FIXED_ONE 8'h80
`define HRAP_CTRL_RW_MASK 8'h07
`endif

/* logic/hrap_pkg.sv */
// Types shared by the host register access block
package hrap_pkg;
   typedef enum logic [1:0] {HRAP_FN_LEGACY, HRAP_FN_BAD1, HRAP_FN_WAKE, HRAP_FN_BAD3} hrap_fn_t;
   typedef struct packed {
      logic        valid;
      logic        write;
      logic        is_io;
      logic        sock_b;
      logic [11:0] addr;
      logic [3:0]  be;
      logic [31:0] wdata;
   } hrap_req_t;
   typedef struct packed {
      logic        int_b_n;
      logic        ring_indicate_output;
      logic        wake_n;
   } hrap_pin_t;
endpackage

/* logic/hrap_host_access.sv */
// Host register access: memory and indexed I/O paths, pin select and bit-type registers
// ********************************************
// ********************************************
`timescale 1ns/1ps
`include "hrap_regs.svh"
module hrap_host_access import hrap_pkg::*; (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Wake-context retention: segment reset from D3 with wake enable set
   input wire logic seg_reset_d3,
   input wire logic wake_enable,
   // Decoded host request, already base-matched per socket
   input wire hrap_req_t req,
   output logic [31:0] rdata,
   output logic ack,
   // Function sources for the shared pin
   input wire logic int_b_src_n,
   input wire logic ring_src,
   input wire logic wake_src_n,
   input wire logic ring_sel_legacy,
   // Hardware event and input pin
   input wire logic event_in,
   input wire logic sense_pin,
   // Shared pin drive and general output pin
   output hrap_pin_t pin_out,
   output logic shared_pin_oe,
   output logic shared_pin_o,
   output logic gp_out_pin
);
   // ********************************************
   // Registers
   // ********************************************
   logic [7:0] pinsel0_q, pinsel1_q, scratch_q, ctrl_q, status_q, index_q, xindex_q;
   logic [1:0] sense_sync_q;
   logic ack_q;
   logic [31:0] rdata_q;
   // Wake-context bits keep their value through the segment reset when wake enable is set
   wire ctx_keep = seg_reset_d3 & wake_enable;
   wire ctx_clear = ~rst_n & ~ctx_keep;
   // ********************************************
   // Address decode
   // ********************************************
   wire mem_acc = req.valid & ~req.is_io;
   wire io_acc = req.valid & req.is_io;
   wire [11:0] mem_word = {req.addr[11:2], 2'b00};
   // Card-bus range is never reached through the index path
   wire mem_cb = mem_acc & (mem_word <= `HRAP_OFF_CB_HI) & (mem_word >= `HRAP_OFF_CB_LO);
   // Index at base, data at base plus one, carried as byte lanes 0 and 1
   wire io_idx_wr = io_acc & req.write & req.be[0];
   wire io_dat_en = io_acc & req.be[1];
   wire [7:0] io_wdata = req.wdata[15:8];
   // Per-socket copies differ by 40h; chip registers ignore socket
   wire [7:0] eff_index = io_idx_wr ? req.wdata[7:0] : index_q;
   wire [7:0] idx_local = eff_index & ~`HRAP_IDX_SOCK_B;
   wire is_xdata = (idx_local == `HRAP_IDX_EXT_DATA);
   // Extended data reaches the pin select bytes through the second index
   wire io_pinsel0 = io_dat_en & is_xdata & (xindex_q == `HRAP_XIDX_PINSEL0);
   wire io_pinsel1 = io_dat_en & is_xdata & (xindex_q == `HRAP_XIDX_PINSEL1);
   wire io_xidx = io_dat_en & (idx_local == `HRAP_IDX_EXT_INDEX);
   wire io_scr = io_dat_en & (idx_local == `HRAP_IDX_SCRATCH);
   wire io_sta = io_dat_en & (idx_local == `HRAP_IDX_STATUS);
   wire io_ctl = io_dat_en & (idx_local == `HRAP_IDX_CTRL);
   wire io_inp = io_dat_en & (idx_local == `HRAP_IDX_INPIN);
   // Memory byte lanes let 8, 16 and 32-bit accesses hit any byte
   wire mem_chip = mem_acc & (mem_word == `HRAP_OFF_PINSEL0);
   wire mem_misc = mem_acc & (mem_word == `HRAP_OFF_SCRATCH);
   wire wr = req.write;
   wire we_pinsel0 = wr & ((mem_chip & req.be[0]) | io_pinsel0);
   wire we_pinsel1 = wr & ((mem_chip & req.be[1]) | io_pinsel1);
   wire we_scr = wr & ((mem_misc & req.be[0]) | io_scr);
   wire we_sta = wr & ((mem_misc & req.be[1]) | io_sta);
   wire we_ctl = wr & ((mem_misc & req.be[2]) | io_ctl);
   wire we_xidx = wr & io_xidx;
   wire [7:0] wd_pinsel0 = io_acc ? io_wdata : req.wdata[7:0];
   wire [7:0] wd_pinsel1 = io_acc ? io_wdata : req.wdata[15:8];
   wire [7:0] wd_scr = io_acc ? io_wdata : req.wdata[7:0];
   wire [7:0] wd_sta = io_acc ? io_wdata : req.wdata[15:8];
   wire [7:0] wd_ctl = io_acc ? io_wdata : req.wdata[23:16];
   // Reserved bits 7:2 never store
   wire [7:0] pinsel1_d = {6'h00, wd_pinsel1[`HRAP_PINSEL_MSB:`HRAP_PINSEL_LSB]};
   // Sticky bit 0: set wins over clear-by-one
   wire [7:0] status_d = {7'h00, event_in | (status_q[0] & ~(we_sta & wd_sta[0]))};
   // Bit 7 fixed one, bits 2:0 writable, rest zero
   wire [7:0] ctrl_d = `HRAP_CTRL_FIXED_ONE | (wd_ctl & `HRAP_CTRL_RW_MASK);
   // ********************************************
   // Storage
   // ********************************************
   always_ff @(posedge clk_sys) begin
      if (ctx_clear) begin
         pinsel0_q <= `HRAP_RST_BYTE;
         pinsel1_q <= `HRAP_RST_BYTE;
      end else begin
         if (we_pinsel0) pinsel0_q <= wd_pinsel0;
         if (we_pinsel1) pinsel1_q <= pinsel1_d;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         scratch_q <= `HRAP_RST_BYTE;
         ctrl_q <= `HRAP_CTRL_FIXED_ONE;
         status_q <= `HRAP_RST_BYTE;
         index_q <= `HRAP_RST_BYTE;
         xindex_q <= `HRAP_RST_BYTE;
      end else begin
         if (we_scr) scratch_q <= wd_scr;
         if (we_ctl) ctrl_q <= ctrl_d;
         status_q <= status_d;
         if (io_idx_wr) index_q <= req.wdata[7:0];
         if (we_xidx) xindex_q <= io_wdata;
      end
   end
   // Input pin crosses in through two flops
   always_ff @(posedge clk_sys) begin
      if (!rst_n) sense_sync_q <= 2'b00;
      else sense_sync_q <= {sense_sync_q[0], sense_pin};
   end
   // ********************************************
   // Read path
   // ********************************************
   wire [7:0] inp_byte = {7'h00, sense_sync_q[1]};
   wire [7:0] io_rd = io_pinsel0 ? pinsel0_q :
                      io_pinsel1 ? pinsel1_q :
                      io_xidx ? xindex_q :
                      io_scr ? scratch_q :
                      io_sta ? status_q :
                      io_ctl ? ctrl_q :
                      io_inp ? inp_byte : 8'h00;
   wire [31:0] mem_rd = mem_chip ? {16'h0000, pinsel1_q, pinsel0_q} :
                        mem_misc ? {inp_byte, ctrl_q, status_q, scratch_q} :
                        32'h0000_0000; // Card-bus group lives outside this block
   wire [31:0] rd_d = io_acc ? {16'h0000, io_rd, index_q} : mem_rd;
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ack_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end else begin
         ack_q <= req.valid & ~mem_cb;
         if (req.valid & ~req.write) rdata_q <= rd_d;
      end
   end
   assign ack = ack_q;
   assign rdata = rdata_q;
   // ********************************************
   // Pin function
   // ********************************************
   // Codes 01 and 11 fall back to legacy; software should avoid them
   hrap_fn_t fn_sel;
   assign fn_sel = hrap_fn_t'(pinsel1_q[1:0]);
   wire wake_mode = (fn_sel == HRAP_FN_WAKE);
   // Enable bit 0 active high, disable bit 1 active high; bit 2 is compatibility only
   wire out_en = ctrl_q[0] & ~ctrl_q[1];
   wire legacy_level = ring_sel_legacy ? ~ring_src : int_b_src_n;
   assign shared_pin_o = 1'b0;
   // Open-drain: drive low only when the selected function asserts
   assign shared_pin_oe = out_en & (wake_mode ? ~wake_src_n : ~legacy_level);
   assign pin_out.int_b_n = wake_mode | ~out_en | int_b_src_n;
   assign pin_out.ring_indicate_output = ~wake_mode & out_en & ring_sel_legacy & ring_src;
   assign pin_out.wake_n = ~wake_mode | wake_src_n;
   assign gp_out_pin = scratch_q[7] & ctrl_q[0];
   // ********************************************
   // Checks
   // ********************************************
   property p_wake_sel;
      @(posedge clk_sys) disable iff (!rst_n)
      (pinsel1_q[1:0] == 2'b10 && ctrl_q[1:0] == 2'b01 && !wake_src_n) |-> shared_pin_oe;
   endproperty
   a_wake_sel: assert property (p_wake_sel) else $error("wake select not driving pin");
   property p_bad_code;
      @(posedge clk_sys) disable iff (!rst_n)
      (pinsel1_q[0] == 1'b1) |-> (pin_out.wake_n == 1'b1);
   endproperty
   a_bad_code: assert property (p_bad_code) else $error("illegal code not legacy");
   property p_reserved;
      @(posedge clk_sys) disable iff (!rst_n)
      we_pinsel1 |=> (pinsel1_q[7:2] == 6'h00);
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits stored");
   property p_cb_only_mem;
      @(posedge clk_sys) disable iff (!rst_n)
      (req.valid && mem_cb) |=> !ack;
   endproperty
   a_cb_only_mem: assert property (p_cb_only_mem) else $error("card-bus access answered");
   property p_index_wr;
      @(posedge clk_sys) disable iff (!rst_n)
      io_idx_wr |=> (index_q == $past(req.wdata[7:0]));
   endproperty
   a_index_wr: assert property (p_index_wr) else $error("index not updated");
   property p_scratch;
      @(posedge clk_sys) disable iff (!rst_n)
      we_scr ##1 (!we_scr)[*2] |-> (scratch_q == $past(wd_scr, 2));
   endproperty
   a_scratch: assert property (p_scratch) else $error("scratch lost value");
   property p_sticky;
      @(posedge clk_sys) disable iff (!rst_n)
      event_in |=> status_q[0];
   endproperty
   a_sticky: assert property (p_sticky) else $error("sticky event lost");
   property p_fixed;
      @(posedge clk_sys) disable iff (!rst_n)
      ack |-> (ctrl_q[7:3] == 5'h10);
   endproperty
   a_fixed: assert property (p_fixed) else $error("fixed bits changed");
   property p_reset;
      @(posedge clk_sys) (!rst_n && !ctx_keep) |=> (pinsel1_q == 8'h00 && pinsel0_q == 8'h00);
   endproperty
   a_reset: assert property (p_reset) else $error("reset value wrong");
   property p_keep;
      @(posedge clk_sys) (!rst_n && ctx_keep) |=> $stable(pinsel1_q);
   endproperty
   a_keep: assert property (p_keep) else $error("wake context lost");
endmodule // hrap_host_access

/* bench/hrap_host_model.sv */
// Host-side model that issues one register access and collects the answer
`timescale 1ns/1ps
module hrap_host_model import hrap_pkg::*; (
   // Clock
   input wire logic clk_sys,
   // Register bus
   output hrap_req_t req,
   input wire logic [31:0] rdata,
   input wire logic ack
);
   initial req = '0;
   // Valid is a one-cycle pulse; ack and rdata are read while they stand in the next cycle
   task automatic xfer(input logic w, io, sb, input logic [11:0] a, input logic [3:0] be,
         input logic [31:0] wd, output logic [31:0] rd, output logic ok);
      @(posedge clk_sys);
      #1 req = '{1'b1, w, io, sb, a, be, wd};
      @(posedge clk_sys);
      #1 ok = ack;
      rd = rdata;
      req.valid = 1'b0;
      // Stale data is inverted so a late capture cannot pass by luck
      req.wdata = ~wd;
   endtask
endmodule // hrap_host_model

/* bench/hrap_host_access_test.sv */
// Self-checking bench for host register access and pin select
`timescale 1ns/1ps
`include "hrap_regs.svh"
module hrap_host_access_test import hrap_pkg::*; ();
   logic clk_sys, rst_n, seg_reset_d3, wake_enable, int_b_src_n, ring_src, wake_src_n;
   logic ring_sel_legacy, event_in, sense_pin, ack, shared_pin_oe, shared_pin_o, gp_out_pin;
   logic ok;
   logic [31:0] rdata, rd;
   hrap_req_t req;
   hrap_pin_t pin_out;
   int miscompares = 0, n_compared = 0, cycles = 0, seed = 31375;
   int sel0, sel1, scr, st, ctl, d;
   hrap_host_access i_dut (.clk_sys, .rst_n, .seg_reset_d3, .wake_enable, .req, .rdata, .ack,
      .int_b_src_n, .ring_src, .wake_src_n, .ring_sel_legacy, .event_in, .sense_pin,
      .pin_out, .shared_pin_oe, .shared_pin_o, .gp_out_pin);
   hrap_host_model i_host (.clk_sys, .req, .rdata, .ack);
   initial begin
      clk_sys = 0;
      forever #20 clk_sys = ~clk_sys;
   end
   // A hang is cut short well beyond the roughly 130 cycles of the run
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         stop_test();
      end
   end
   // ********************************************
   // Reference model and helpers
   // ********************************************
   function automatic logic [31:0] w914();
      return {16'h0, sel1[7:0], sel0[7:0]};
   endfunction
   function automatic logic [31:0] w918();
      return {7'h00, sense_pin, ctl[7:0], st[7:0], scr[7:0]};
   endfunction
   task automatic check(input logic [31:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic io, input logic [11:0] a, input logic [3:0] be, input int v);
      i_host.xfer(1'b1, io, 1'b0, a, be, v, rd, ok);
   endtask
   task automatic rdchk(input logic io, sb, input logic [11:0] a, input logic [31:0] exp);
      i_host.xfer(1'b0, io, sb, a, io ? 4'h2 : 4'hf, 32'h0, rd, ok);
      check(ok, 1'b1);
      check(rd, exp);
   endtask
   task automatic pin(input logic wk, ib, exp);
      #1 wake_src_n = wk;
      int_b_src_n = ib;
      repeat (2) @(posedge clk_sys);
      #1 check(shared_pin_oe, exp);
      check(shared_pin_o, 1'b0);
   endtask
   task automatic do_reset(input logic keep, input int n);
      #1 rst_n = 0;
      seg_reset_d3 = keep;
      wake_enable = keep;
      repeat (n) @(posedge clk_sys);
      #1 rst_n = 1;
      seg_reset_d3 = 0;
      if (!keep) begin
         sel0 = 0;
         sel1 = 0;
      end
      scr = 0;
      st = 0;
      ctl = 'h80;
   endtask
   task automatic stop_test();
      if (miscompares == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // ********************************************
   // Main sequence
   // ********************************************
   initial begin
      rst_n = 0;
      {seg_reset_d3, wake_enable, ring_src, ring_sel_legacy, event_in, sense_pin} = '0;
      {int_b_src_n, wake_src_n} = 2'b11;
      do_reset(1'b0, 20);
      rdchk(1'b0, 1'b0, `HRAP_OFF_PINSEL0, w914());
      rdchk(1'b0, 1'b0, `HRAP_OFF_SCRATCH, w918());
      // Byte, half-word and word writes with random data, read back on both sockets
      for (int i = 0; i < 3; i++) begin
         d = $random(seed);
         wr(1'b0, `HRAP_OFF_SCRATCH, (i == 0) ? 4'h1 : (i == 1) ? 4'h3 : 4'hf, d);
         scr = d & 'hff;
         if (i == 2) ctl = 'h80 | ((d >> 16) & 'h07);
         rdchk(1'b0, i[0], `HRAP_OFF_SCRATCH, w918());
      end
      // Output enable on, disable off, so the shared pin may be driven
      wr(1'b0, `HRAP_OFF_SCRATCH, 4'h4, 32'h0001_0000);
      ctl = 'h81;
      // Every select code, with the reserved bits written as ones on purpose
      for (int c = 0; c < 4; c++) begin
         wr(1'b0, `HRAP_OFF_PINSEL0, 4'h2, (c | 'hfc) << 8);
         sel1 = c;
         rdchk(1'b0, 1'b0, `HRAP_OFF_PINSEL0, w914());
         pin(1'b0, 1'b1, c == 2);
         pin(1'b1, 1'b0, c != 2);
      end
      // Indexed path: one 16-bit write sets index and data
      d = $random(seed) & 'hff;
      wr(1'b1, 12'h0, 4'h3, (d << 8) | `HRAP_IDX_SCRATCH);
      scr = d;
      rdchk(1'b0, 1'b0, `HRAP_OFF_SCRATCH, w918());
      wr(1'b1, 12'h0, 4'h1, `HRAP_IDX_SCRATCH + `HRAP_IDX_SOCK_B);
      rdchk(1'b1, 1'b0, 12'h0, {16'h0, scr[7:0], 8'h4e});
      wr(1'b1, 12'h0, 4'h3, 'h152e);
      wr(1'b1, 12'h0, 4'h3, 'h022f);
      sel1 = 2;
      rdchk(1'b0, 1'b0, `HRAP_OFF_PINSEL0, w914());
      rdchk(1'b1, 1'b0, 12'h0, 32'h022f);
      // Card-bus range gets no answer; an unmapped word reads zero
      i_host.xfer(1'b0, 1'b0, 1'b0, 12'h100, 4'hf, 32'h0, rd, ok);
      check(ok, 1'b0);
      rdchk(1'b0, 1'b0, 12'h920, 32'h0);
      // Sticky status: set by the event, zero write keeps it, one write clears it
      #1 event_in = 1;
      @(posedge clk_sys);
      #1 event_in = 0;
      repeat (4) @(posedge clk_sys);
      st = 1;
      for (int v = 0; v < 2; v++) begin
         wr(1'b0, `HRAP_OFF_SCRATCH, 4'h2, v << 8);
         rdchk(1'b0, 1'b0, `HRAP_OFF_SCRATCH, w918());
         st = 0;
      end
      // Output pin follows scratch bit 7 gated by the enable bit
      for (int k = 0; k < 4; k++) begin
         wr(1'b0, `HRAP_OFF_SCRATCH, 4'h5, ((k & 1) << 16) | ((k >> 1) << 7));
         scr = (k >> 1) << 7;
         ctl = 'h80 | (k & 1);
         #1 check(gp_out_pin, k == 3);
      end
      // Input bit follows the pin through the two-flop crossing
      sense_pin = 1;
      repeat (3) @(posedge clk_sys);
      rdchk(1'b0, 1'b0, `HRAP_OFF_SCRATCH, w918());
      #1 sense_pin = 0;
      repeat (3) @(posedge clk_sys);
      // Select bytes survive only the wake-context reset
      wr(1'b0, `HRAP_OFF_PINSEL0, 4'h3, 'h0255);
      sel0 = 'h55;
      do_reset(1'b1, 2);
      rdchk(1'b0, 1'b0, `HRAP_OFF_PINSEL0, w914());
      rdchk(1'b0, 1'b0, `HRAP_OFF_SCRATCH, w918());
      do_reset(1'b0, 2);
      rdchk(1'b0, 1'b0, `HRAP_OFF_PINSEL0, w914());
      stop_test();
   end
endmodule // hrap_host_access_test
